// ---- verilog/radio_irq_pkg.sv ----
// Constants shared by the radio interrupt and status logic.
// Assumes an 8-bit register file reached by a byte-wide register port.
package radio_irq_pkg;

  // Register port shape and FIFO count width
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 7;

  // Register offsets
  localparam logic [6:0] ADDR_STATUS1 = 7'h03;
  localparam logic [6:0] ADDR_STATUS2 = 7'h04;
  localparam logic [6:0] ADDR_ENABLE1 = 7'h05;
  localparam logic [6:0] ADDR_ENABLE2 = 7'h06;

  // First group field positions
  localparam int BIT_FIFO_ERR   = 7;
  localparam int BIT_TX_AFULL   = 6;
  localparam int BIT_TX_AEMPTY  = 5;
  localparam int BIT_RX_AFULL   = 4;
  localparam int BIT_EXT        = 3;
  localparam int BIT_PKT_SENT   = 2;
  localparam int BIT_PKT_VALID  = 1;
  localparam int BIT_CRC_ERR    = 0;

  // Second group field positions
  localparam int BIT_SYNC_DET   = 7;
  localparam int BIT_PRE_VALID  = 6;
  localparam int BIT_PRE_INVAL  = 5;
  localparam int BIT_RSSI       = 4;
  localparam int BIT_WAKE_TIMER = 3;
  localparam int BIT_LOW_BATT   = 2;
  localparam int BIT_CHIP_READY = 1;
  localparam int BIT_POWER_ON   = 0;

  // Reset values
  localparam logic [7:0] RESET_STATUS = 8'h00;
  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Second group sources that latch even while disabled
  localparam logic [7:0] LATCH_ALWAYS2 = 8'h04;

endpackage

// ---- verilog/radio_interrupt_status_logic.sv ----
// Interrupt and status registers of a packet radio, with the IRQ pin.
// Assumes the SPI engine turns host accesses into one-cycle read and
// write strobes, and that all event inputs are synchronous to CLK.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1 - FIFO error sets on over/underflow, clears only on that FIFO's reset.
// R2 - TX almost-full high while TX count exceeds its threshold.
// R3 - TX almost-empty high while TX count is at or below its threshold.
// R4 - RX almost-full high while RX count exceeds threshold, clears below it.
// R5 - Packet sent sets on completion, clears leaving FIFO mode or new start.
// R6 - Valid packet sets on good reception, clears on next sync acknowledge.
// R7 - CRC error sets on mismatch, clears when next reception begins.
// R8 - Sync word detection sets second-group bit 7.
// R9 - Valid preamble detection sets second-group bit 6.
// R10 - Preamble timeout after receiver enable sets second-group bit 5.
// R11 - Signal strength above threshold sets second-group bit 4.
// R12 - Wake-up timer expiry sets second-group bit 3.
// R13 - Low battery latches while disabled, interrupts once enabled.
// R14 - Crystal ready event sets second-group bit 1.
// R15 - Power-on detection sets second-group bit 0.
// R16 - Enabled second-group rising bit pulls the interrupt line low.
// R17 - Reading second status clears enabled bits; line releases if no enabled first-group bit is pending.
// R18 - Disabled bits read as plain status, unchanged by reads.
// R19 - First group interrupts likewise; its status read clears enabled bits.
// R20 - First enable register holds one read-write enable per first-group bit.
// R21 - Interrupt line low while any enabled pending bit remains set.
module radio_interrupt_status_logic
  import radio_irq_pkg::*;
#(
  parameter int CW = radio_irq_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RST_N,
  // Register port from the SPI engine
  input  wire logic [radio_irq_pkg::ADDR_W-1:0] REG_ADDR,
  input  wire logic                          REG_RD,
  input  wire logic                          REG_WR,
  input  wire logic [radio_irq_pkg::DATA_W-1:0] REG_WDATA,
  output logic      [radio_irq_pkg::DATA_W-1:0] REG_RDATA,
  // FIFO events and levels, external interrupt
  input  wire logic                          FIFO_ERR_TX,
  input  wire logic                          FIFO_ERR_RX,
  input  wire logic                          TX_FIFO_RESET,
  input  wire logic                          RX_FIFO_RESET,
  input  wire logic [CW-1:0]                 TX_COUNT,
  input  wire logic [CW-1:0]                 TX_AFULL_THR,
  input  wire logic [CW-1:0]                 TX_AEMPTY_THR,
  input  wire logic [CW-1:0]                 RX_COUNT,
  input  wire logic [CW-1:0]                 RX_AFULL_THR,
  input  wire logic                          EXT_INT,
  // Packet handler events
  input  wire logic                          FIFO_MODE,
  input  wire logic                          TX_START,
  input  wire logic                          PKT_SENT,
  input  wire logic                          PKT_VALID,
  input  wire logic                          SYNC_ACK,
  input  wire logic                          RX_START,
  input  wire logic                          CRC_FAIL,
  // Receiver and system events
  input  wire logic                          SYNC_DET,
  input  wire logic                          PKT_DONE,
  input  wire logic                          PREAMBLE_DET,
  input  wire logic                          SYNC_TIMEOUT,
  input  wire logic                          PREAMBLE_TIMEOUT,
  input  wire logic                          RSSI_ABOVE,
  input  wire logic                          WAKE_TIMER_EXPIRE,
  input  wire logic                          LOW_BATT,
  input  wire logic                          BATT_OK,
  input  wire logic                          CHIP_READY,
  input  wire logic                          POWER_ON_EVENT,
  // Interrupt pin, active low
  output logic                               INTERRUPT_LINE_N
);

  logic [7:0] raw1;
  logic [7:0] raw2;
  logic [7:0] next_raw1;
  logic [7:0] next_raw2;
  logic       tx_err;
  logic       rx_err;
  logic       next_tx_err;
  logic       next_rx_err;
  logic [7:0] en1;
  logic [7:0] en2;
  logic [7:0] next_en1;
  logic [7:0] next_en2;
  logic [7:0] pend1;
  logic [7:0] pend2;
  logic [7:0] next_pend1;
  logic [7:0] next_pend2;
  logic [7:0] rise1;
  logic [7:0] rise2;
  logic [7:0] view1;
  logic [7:0] view2;
  logic [7:0] next_rdata;
  logic       next_irq_n;
  logic       rd1;
  logic       rd2;

  assign rd1 = REG_RD && (REG_ADDR == ADDR_STATUS1);
  assign rd2 = REG_RD && (REG_ADDR == ADDR_STATUS2);

  // Raw source state; set terms are ORed last so a set beats a clear
  always_comb begin
    next_tx_err = (tx_err & ~TX_FIFO_RESET) | FIFO_ERR_TX; // [R1]
    next_rx_err = (rx_err & ~RX_FIFO_RESET) | FIFO_ERR_RX; // [R1]
    next_raw1 = raw1;
    next_raw1[BIT_FIFO_ERR]  = next_tx_err | next_rx_err; // [R1]
    next_raw1[BIT_TX_AFULL]  = TX_COUNT > TX_AFULL_THR; // [R2]
    next_raw1[BIT_TX_AEMPTY] = TX_COUNT <= TX_AEMPTY_THR; // [R3]
    // Holds at the threshold itself; only a drop below clears it
    next_raw1[BIT_RX_AFULL]  = (raw1[BIT_RX_AFULL]
                                & (RX_COUNT >= RX_AFULL_THR))
                               | (RX_COUNT > RX_AFULL_THR); // [R4]
    next_raw1[BIT_EXT]       = EXT_INT;
    next_raw1[BIT_PKT_SENT]  = (raw1[BIT_PKT_SENT] & FIFO_MODE & ~TX_START)
                               | PKT_SENT; // [R5]
    next_raw1[BIT_PKT_VALID] = (raw1[BIT_PKT_VALID] & ~SYNC_ACK)
                               | PKT_VALID; // [R6]
    next_raw1[BIT_CRC_ERR]   = (raw1[BIT_CRC_ERR] & ~RX_START)
                               | CRC_FAIL; // [R7]
    next_raw2 = raw2;
    next_raw2[BIT_SYNC_DET]   = (raw2[BIT_SYNC_DET] & ~PKT_DONE)
                                | SYNC_DET; // [R8]
    next_raw2[BIT_PRE_VALID]  = (raw2[BIT_PRE_VALID] & ~SYNC_DET
                                 & ~SYNC_TIMEOUT) | PREAMBLE_DET; // [R9]
    // Pulse-like sources except latched low battery: meaningful as interrupts, not as status
    next_raw2[BIT_PRE_INVAL]  = PREAMBLE_TIMEOUT; // [R10]
    next_raw2[BIT_RSSI]       = RSSI_ABOVE; // [R11]
    next_raw2[BIT_WAKE_TIMER] = WAKE_TIMER_EXPIRE; // [R12]
    next_raw2[BIT_LOW_BATT]   = (raw2[BIT_LOW_BATT] & ~BATT_OK)
                                | LOW_BATT; // [R13]
    next_raw2[BIT_CHIP_READY] = CHIP_READY; // [R14]
    next_raw2[BIT_POWER_ON]   = POWER_ON_EVENT; // [R15]
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      raw1   <= RESET_STATUS;
      raw2   <= RESET_STATUS;
      tx_err <= 1'b0;
      rx_err <= 1'b0;
    end else begin
      raw1   <= next_raw1;
      raw2   <= next_raw2;
      tx_err <= next_tx_err;
      rx_err <= next_rx_err;
    end
  end

  // Enable registers
  always_comb begin
    next_en1 = en1;
    next_en2 = en2;
    if (REG_WR && (REG_ADDR == ADDR_ENABLE1)) begin
      next_en1 = REG_WDATA; // [R20]
    end
    if (REG_WR && (REG_ADDR == ADDR_ENABLE2)) begin
      next_en2 = REG_WDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      en1 <= RESET_ENABLE;
      en2 <= RESET_ENABLE;
    end else begin
      en1 <= next_en1;
      en2 <= next_en2;
    end
  end

  assign rise1 = next_raw1 & ~raw1;
  assign rise2 = next_raw2 & ~raw2;

  // Pending latches; only low battery latches while its enable is off.
  // A rise in the read cycle survives the read-clear.
  always_comb begin
    next_pend1 = (pend1 & ~(rd1 ? en1 : 8'h00))
                 | (rise1 & en1); // [R19]
    next_pend2 = (pend2 & ~(rd2 ? en2 : 8'h00))
                 | (rise2 & (en2 | LATCH_ALWAYS2)); // [R16] [R17] [R13]
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pend1 <= RESET_STATUS;
      pend2 <= RESET_STATUS;
    end else begin
      pend1 <= next_pend1;
      pend2 <= next_pend2;
    end
  end

  // Enabled bits show the interrupt latch, disabled ones live status
  assign view1 = (en1 & pend1) | (~en1 & raw1); // [R18]
  assign view2 = (en2 & pend2) | (~en2 & raw2); // [R18]

  // Read data and pin, both registered
  always_comb begin
    next_rdata = REG_RDATA;
    if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_STATUS1: next_rdata = view1;
        ADDR_STATUS2: next_rdata = view2;
        ADDR_ENABLE1: next_rdata = en1;
        ADDR_ENABLE2: next_rdata = en2;
        default:      next_rdata = READ_UNMAPPED;
      endcase
    end
    next_irq_n = ~|((next_pend1 & next_en1)
                    | (next_pend2 & next_en2)); // [R21]
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      REG_RDATA        <= READ_UNMAPPED;
      INTERRUPT_LINE_N <= 1'b1;
    end else begin
      REG_RDATA        <= next_rdata;
      INTERRUPT_LINE_N <= next_irq_n;
    end
  end

  // Checks
  property p_fifo_err;
    @(posedge CLK) disable iff (!RST_N)
      (FIFO_ERR_TX && !rx_err && !FIFO_ERR_RX) ##1 (!FIFO_ERR_RX
      && !TX_FIFO_RESET)[*2] |-> raw1[BIT_FIFO_ERR];
  endproperty
  a_fifo_err: assert property (p_fifo_err) // [R1]
    else $error("FIFO error bit dropped without a FIFO reset");

  property p_tx_afull;
    @(posedge CLK) disable iff (!RST_N)
      (TX_COUNT > TX_AFULL_THR) |=> raw1[BIT_TX_AFULL];
  endproperty
  a_tx_afull: assert property (p_tx_afull) // [R2]
    else $error("TX almost-full not set above threshold");

  property p_tx_aempty;
    @(posedge CLK) disable iff (!RST_N)
      (TX_COUNT > TX_AEMPTY_THR) |=> !raw1[BIT_TX_AEMPTY];
  endproperty
  a_tx_aempty: assert property (p_tx_aempty) // [R3]
    else $error("TX almost-empty set above threshold");

  property p_rx_afull;
    @(posedge CLK) disable iff (!RST_N)
      (RX_COUNT < RX_AFULL_THR) |=> !raw1[BIT_RX_AFULL];
  endproperty
  a_rx_afull: assert property (p_rx_afull) // [R4]
    else $error("RX almost-full held below threshold");

  property p_pkt_sent;
    @(posedge CLK) disable iff (!RST_N)
      (!FIFO_MODE && !PKT_SENT) |=> !raw1[BIT_PKT_SENT];
  endproperty
  a_pkt_sent: assert property (p_pkt_sent) // [R5]
    else $error("Packet sent kept outside FIFO mode");

  property p_crc;
    @(posedge CLK) disable iff (!RST_N)
      CRC_FAIL ##1 !RX_START |=> raw1[BIT_CRC_ERR];
  endproperty
  a_crc: assert property (p_crc) // [R7]
    else $error("CRC error not held until next reception");

  property p_low_batt;
    @(posedge CLK) disable iff (!RST_N)
      (LOW_BATT && !raw2[BIT_LOW_BATT]) |=> pend2[BIT_LOW_BATT];
  endproperty
  a_low_batt: assert property (p_low_batt) // [R13]
    else $error("Low battery event not latched");

  property p_irq_low;
    @(posedge CLK) disable iff (!RST_N)
      ((rise2 & en2) != 8'h00) && !REG_WR |=> !INTERRUPT_LINE_N;
  endproperty
  a_irq_low: assert property (p_irq_low) // [R16]
    else $error("Enabled rise did not pull the line low");

  property p_read2_clear;
    @(posedge CLK) disable iff (!RST_N)
      (rd2 && !REG_WR) |=> ((pend2 & en2 & ~$past(rise2)) == 8'h00);
  endproperty
  a_read2_clear: assert property (p_read2_clear) // [R17]
    else $error("Second status read left enabled bits set");

  property p_read1_clear;
    @(posedge CLK) disable iff (!RST_N)
      (rd1 && !REG_WR) |=> ((pend1 & en1 & ~$past(rise1)) == 8'h00);
  endproperty
  a_read1_clear: assert property (p_read1_clear) // [R19]
    else $error("First status read left enabled bits set");

  property p_disabled_view;
    @(posedge CLK) disable iff (!RST_N)
      rd2 |=> ((REG_RDATA & ~$past(en2)) == ($past(raw2) & ~$past(en2)));
  endproperty
  a_disabled_view: assert property (p_disabled_view) // [R18]
    else $error("Disabled bit did not read as live status");

  property p_irq_level;
    @(posedge CLK) disable iff (!RST_N)
      1'b1 |=> (INTERRUPT_LINE_N
                == (((pend1 & en1) | (pend2 & en2)) == 8'h00));
  endproperty
  a_irq_level: assert property (p_irq_level) // [R21]
    else $error("Interrupt line disagrees with pending bits");

  property p_rx_afull_hold;
    @(posedge CLK) disable iff (!RST_N)
      (raw1[BIT_RX_AFULL] && (RX_COUNT == RX_AFULL_THR))
      |=> raw1[BIT_RX_AFULL];
  endproperty
  a_rx_afull_hold: assert property (p_rx_afull_hold) // [R4]
    else $error("RX almost-full dropped at the threshold");

  property p_pkt_start;
    @(posedge CLK) disable iff (!RST_N)
      (TX_START && !PKT_SENT) |=> !raw1[BIT_PKT_SENT];
  endproperty
  a_pkt_start: assert property (p_pkt_start) // [R5]
    else $error("Packet sent kept across a new transmission");

  property p_pkt_valid;
    @(posedge CLK) disable iff (!RST_N)
      (SYNC_ACK && !PKT_VALID) |=> !raw1[BIT_PKT_VALID];
  endproperty
  a_pkt_valid: assert property (p_pkt_valid) // [R6]
    else $error("Valid packet kept after sync acknowledge");

  property p_sync_det;
    @(posedge CLK) disable iff (!RST_N)
      SYNC_DET |=> raw2[BIT_SYNC_DET];
  endproperty
  a_sync_det: assert property (p_sync_det) // [R8]
    else $error("Sync word detection not recorded");

  property p_pre_valid;
    @(posedge CLK) disable iff (!RST_N)
      PREAMBLE_DET |=> raw2[BIT_PRE_VALID];
  endproperty
  a_pre_valid: assert property (p_pre_valid) // [R9]
    else $error("Valid preamble not recorded");

  property p_en1_write;
    @(posedge CLK) disable iff (!RST_N)
      (REG_WR && (REG_ADDR == ADDR_ENABLE1)) |=> (en1 == $past(REG_WDATA));
  endproperty
  a_en1_write: assert property (p_en1_write) // [R20]
    else $error("First enable register did not take the write");

endmodule // radio_interrupt_status_logic

`default_nettype wire

// ---- verif/radio_host_model.sv ----
// Host microcontroller model driving the byte-wide register port.
// Assumes one access per call, launched just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module radio_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [6:0] addr,
  output logic            rd,
  output logic            wr,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata
);
  initial begin
    addr = 7'h7f;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 8'h5a;
  end

  // Idle address and data flip so stale values never pass for valid
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    addr = ~a;
    d = rdata; // Status read acknowledges pending sources
  endtask

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
    addr = ~a;
    wdata = ~v;
  endtask
endmodule // radio_host_model
`default_nettype wire

// ---- verif/radio_interrupt_status_logic_bench.sv ----
// Self-checking bench for the radio interrupt and status logic.
// Assumes the host model file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module radio_interrupt_status_logic_bench;
  import radio_irq_pkg::*;
  typedef struct {int s; int c; logic [6:0] a; logic [7:0] m;} row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [18:0] ev = '0;
  logic [3:0]  lv = 4'h2;
  logic [6:0]  txc = 7'h05, txf = 7'h08, txe = 7'h04;
  logic [6:0]  rxc = 7'h00, rxf = 7'h08, addr;
  logic        rd, wr, irq_n;
  logic [7:0]  wdata, rdata, d;
  int          bad_count = 0, num_checks = 0;
  // Set pulse, clear pulse, register, expected raw view
  row_t rows [7] = '{
    '{0, 2, 7'h03, 8'h80},
    '{5, 4, 7'h03, 8'h04},
    '{6, 7, 7'h03, 8'h02},
    '{9, 8, 7'h03, 8'h01},
    '{10, 11, 7'h04, 8'h80},
    '{12, 13, 7'h04, 8'h40},
    '{16, 17, 7'h04, 8'h04}};

  always #10 clk = ~clk;

  radio_host_model host (.clk(clk), .addr(addr), .rd(rd), .wr(wr),
    .wdata(wdata), .rdata(rdata));

  radio_interrupt_status_logic DUT (.CLK(clk), .RST_N(rst_n),
    .REG_ADDR(addr), .REG_RD(rd), .REG_WR(wr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .FIFO_ERR_TX(ev[0]), .FIFO_ERR_RX(ev[1]),
    .TX_FIFO_RESET(ev[2]), .RX_FIFO_RESET(ev[3]), .TX_COUNT(txc),
    .TX_AFULL_THR(txf), .TX_AEMPTY_THR(txe), .RX_COUNT(rxc),
    .RX_AFULL_THR(rxf), .EXT_INT(lv[0]), .FIFO_MODE(lv[1]),
    .TX_START(ev[4]), .PKT_SENT(ev[5]), .PKT_VALID(ev[6]),
    .SYNC_ACK(ev[7]), .RX_START(ev[8]), .CRC_FAIL(ev[9]),
    .SYNC_DET(ev[10]), .PKT_DONE(ev[11]), .PREAMBLE_DET(ev[12]),
    .SYNC_TIMEOUT(ev[13]), .PREAMBLE_TIMEOUT(ev[14]),
    .RSSI_ABOVE(lv[2]), .WAKE_TIMER_EXPIRE(ev[15]), .LOW_BATT(ev[16]),
    .BATT_OK(ev[17]), .CHIP_READY(lv[3]), .POWER_ON_EVENT(ev[18]),
    .INTERRUPT_LINE_N(irq_n));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t ns: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    host.rd_reg(a, d);
    chk(d, exp);
  endtask

  task automatic pin(input logic exp);
    chk({7'h00, irq_n}, {7'h00, exp});
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    #1;
    ev[i] = 1'b1;
    @(posedge clk);
    #1;
    ev[i] = 1'b0;
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run is well under 2000 cycles
  initial begin
    #100000;
    bad_count++;
    $display("Watchdog expired");
    stop_test();
  end

  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    pin(1'b1);
    rchk(7'h05, 8'h00);
    rchk(7'h04, 8'h00);
    rchk(7'h7f, 8'h00);
    host.wr_reg(7'h05, 8'ha5);
    rchk(7'h05, 8'ha5);
    host.wr_reg(7'h05, 8'h00);
    $display("Test reset and enable done");
    foreach (rows[i]) begin
      pulse(rows[i].s);
      rchk(rows[i].a, rows[i].m);
      rchk(rows[i].a, rows[i].m);
      pin(1'b1);
      pulse(rows[i].c);
      rchk(rows[i].a, 8'h00);
    end
    $display("Test event table done");
    // Low battery pending from the table fires once enabled
    host.wr_reg(7'h06, 8'h04);
    repeat (3) @(posedge clk);
    pin(1'b0);
    rchk(7'h04, 8'h04);
    pin(1'b1);
    $display("Test low battery done");
    txc = 7'h09;
    rxc = 7'h09;
    rchk(7'h03, 8'h50);
    rxc = 7'h08;
    rchk(7'h03, 8'h50);
    txc = 7'h04;
    rxc = 7'h07;
    rchk(7'h03, 8'h20);
    txc = 7'h08;
    rchk(7'h03, 8'h00);
    txc = 7'h05;
    rxc = 7'h00;
    $display("Test FIFO levels done");
    host.wr_reg(7'h06, 8'h29);
    pulse(14);
    pin(1'b0);
    pulse(15);
    rchk(7'h04, 8'h28);
    pin(1'b1);
    host.wr_reg(7'h05, 8'h80);
    pulse(18);
    pulse(0);
    rchk(7'h04, 8'h01);
    pin(1'b0);
    rchk(7'h03, 8'h80);
    pin(1'b1);
    rchk(7'h03, 8'h00);
    $display("Test both groups done");
    host.wr_reg(7'h05, 8'h00);
    rchk(7'h03, 8'h80);
    pulse(3);
    rchk(7'h03, 8'h80);
    pulse(2);
    rchk(7'h03, 8'h00);
    pulse(1);
    rchk(7'h03, 8'h80);
    pulse(2);
    rchk(7'h03, 8'h80);
    pulse(3);
    rchk(7'h03, 8'h00);
    $display("Test FIFO error reset done");
    pulse(5);
    rchk(7'h03, 8'h04);
    lv[1] = 1'b0;
    rchk(7'h03, 8'h00);
    lv[1] = 1'b1;
    lv[0] = 1'b1;
    rchk(7'h03, 8'h08);
    lv[0] = 1'b0;
    rchk(7'h03, 8'h00);
    pulse(12);
    pulse(10);
    rchk(7'h04, 8'h80);
    pulse(11);
    rchk(7'h04, 8'h00);
    $display("Test status clears done");
    host.wr_reg(7'h06, 8'h12);
    lv[3:2] = 2'b11;
    repeat (2) @(posedge clk);
    pin(1'b0);
    rchk(7'h04, 8'h12);
    pin(1'b1);
    $display("Test level sources done");
    // Reset again mid-run: enables and latches drop, levels return
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    pin(1'b1);
    rchk(7'h06, 8'h00);
    rchk(7'h04, 8'h12);
    rchk(7'h03, 8'h00);
    $display("Test mid-run reset done");
    stop_test();
  end
endmodule // radio_interrupt_status_logic_bench
`default_nettype wire
